// ===== see_top.sv
// Overview of operation
// R01: Sample data on clock rise, shift on fall
// R02: Open-drain data: only pull low or release
// R03: Selection bits must match three strap pins
// R04: Unconnected straps read as logic zero
// R05: Protect high blocks all array writes
// R06: Protect low allows normal reads and writes
// R07: 32768 bytes, 15-bit word address
// R08: 512 pages of 64 bytes
// R09: Page write up to 64, partial allowed
// R10: Self-timed programming ends within 5 ms
// R11: Controller keeps serial clock within limits
// R12: Start is data falling while clock high
// R13: Stop is data rising while clock high
// R14: Acknowledge each received byte on ninth clock
// R15: Data changes only while clock low
// R16: No acknowledge while programming runs
// R17: Page write pointer wraps within page
`timescale 1ns/1ps
`default_nettype none
module see_top
    import see_pkg::*;
#(
    parameter int P_WRITE_CYCLES = WRITE_CYCLES
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    // Straps and protect
    input wire logic [STRAP_W-1:0] i_bus_select_straps,
    input wire logic i_protect,
    // Status
    output logic o_busy
);
    logic rst_s1, rst_n;
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic [STRAP_W-1:0] strap_s1, strap_s2;
    logic prot_s1, prot_s2;
    logic scl_rise, scl_fall, start_ev, stop_ev, byte_done;
    see_state_t st;
    see_role_t role;
    logic [3:0] cnt;
    logic [BYTE_W-1:0] sh, tx;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_SEL_W-1:0] wr_page;
    logic [PAGE_BYTES-1:0] valid;
    logic rd_mode, mack, wr_any;
    logic buf_we;
    logic [PAGE_W-1:0] buf_waddr;
    logic [BYTE_W-1:0] buf_wdata, buf_rdata, arr_rdata;
    logic busy;
    logic [TIMER_W-1:0] timer;
    logic [6:0] prog_idx;
    logic copy_vld;
    logic [PAGE_W-1:0] copy_idx;
    logic arr_we;
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end
    // Pins are asynchronous to the system clock; third stage only for edges
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            prot_s1 <= 1'b0;
            prot_s2 <= 1'b0;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {i_scl, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {i_sda, sda_s1, sda_s2};
            strap_s1 <= i_bus_select_straps; // [R04]
            strap_s2 <= strap_s1;
            prot_s1 <= i_protect;
            prot_s2 <= prot_s1;
        end
    end
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign start_ev = scl_s2 & scl_s3 & ~sda_s2 & sda_s3; // [R12]
    assign stop_ev = scl_s2 & scl_s3 & sda_s2 & ~sda_s3; // [R13]
    assign byte_done = scl_fall && (st == ST_RX) && (cnt == BITS_PER_BYTE);
    // Bus protocol; the line is only ever released or pulled low
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_IDLE;
            role <= RL_DEVSEL;
            cnt <= 4'h0;
            sh <= 8'h00;
            tx <= 8'h00;
            addr <= 15'h0000;
            wr_page <= 9'h000;
            valid <= 64'h0;
            rd_mode <= 1'b0;
            mack <= 1'b0;
            wr_any <= 1'b0;
            buf_we <= 1'b0;
            buf_waddr <= 6'h00;
            buf_wdata <= 8'h00;
            o_sda_out <= 1'b0; // [R02]
            o_sda_oe_n <= 1'b1;
        end else begin
            buf_we <= 1'b0;
            if (start_ev) begin
                st <= ST_RX;
                role <= RL_DEVSEL;
                cnt <= 4'h0;
                wr_any <= 1'b0;
                o_sda_oe_n <= 1'b1;
            end else if (stop_ev) begin
                st <= ST_IDLE;
                wr_any <= 1'b0;
                o_sda_oe_n <= 1'b1;
            end else begin
                case (st)
                    ST_RX: begin
                        if (scl_rise) begin
                            sh <= {sh[6:0], sda_s2}; // [R01]
                            cnt <= cnt + 4'h1;
                        end else if (byte_done) begin
                            st <= ST_ACK;
                            o_sda_oe_n <= 1'b0; // [R14]
                            case (role)
                                RL_DEVSEL: begin
                                    // Stay silent while programming so the host can poll
                                    if (sh[7:4] == TYPE_CODE && sh[3:1] == strap_s2
                                        && !busy) begin // [R03] [R16]
                                        rd_mode <= sh[0];
                                        role <= RL_ADDR_HI;
                                    end else begin
                                        st <= ST_IDLE;
                                        o_sda_oe_n <= 1'b1;
                                    end
                                end
                                RL_ADDR_HI: begin
                                    addr[14:8] <= sh[6:0]; // [R07]
                                    role <= RL_ADDR_LO;
                                end
                                RL_ADDR_LO: begin
                                    addr[7:0] <= sh;
                                    wr_page <= {addr[14:8], sh[7:6]}; // [R08]
                                    valid <= 64'h0;
                                    role <= RL_DATA;
                                end
                                default: begin
                                    buf_we <= 1'b1;
                                    buf_waddr <= addr[PAGE_W-1:0];
                                    buf_wdata <= sh;
                                    valid[addr[PAGE_W-1:0]] <= 1'b1; // [R09]
                                    addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 6'h01; // [R17]
                                    wr_any <= 1'b1;
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (rd_mode) begin
                                tx <= {arr_rdata[6:0], 1'b0};
                                o_sda_oe_n <= arr_rdata[7]; // [R01] [R15]
                                addr <= addr + 15'h0001;
                                cnt <= 4'h1;
                                st <= ST_TX;
                            end else begin
                                o_sda_oe_n <= 1'b1;
                                cnt <= 4'h0;
                                st <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (cnt == BITS_PER_BYTE) begin
                                o_sda_oe_n <= 1'b1;
                                st <= ST_TXACK;
                            end else begin
                                o_sda_oe_n <= tx[7];
                                tx <= {tx[6:0], 1'b0};
                                cnt <= cnt + 4'h1;
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            mack <= ~sda_s2;
                        end else if (scl_fall) begin
                            if (mack) begin
                                tx <= {arr_rdata[6:0], 1'b0};
                                o_sda_oe_n <= arr_rdata[7];
                                addr <= addr + 15'h0001;
                                cnt <= 4'h1;
                                st <= ST_TX;
                            end else begin
                                st <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        o_sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end
    // Programming starts on stop; the page is copied in the first cycles,
    // while the timer, started with the copy, runs out the full cycle time
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            timer <= 19'h00000;
            prog_idx <= 7'h00;
            copy_vld <= 1'b0;
            copy_idx <= 6'h00;
            o_busy <= 1'b0;
        end else begin
            copy_vld <= busy && (prog_idx < PAGE_END);
            copy_idx <= prog_idx[PAGE_W-1:0];
            o_busy <= busy;
            if (!busy) begin
                if (stop_ev && wr_any && !prot_s2) begin // [R05] [R06]
                    busy <= 1'b1;
                    timer <= 19'h00000;
                    prog_idx <= 7'h00;
                end
            end else begin
                if (prog_idx < PAGE_END) begin
                    prog_idx <= prog_idx + 7'h01;
                end
                if (timer == TIMER_W'(P_WRITE_CYCLES - 1)) begin // [R10]
                    busy <= 1'b0;
                end else begin
                    timer <= timer + 19'h00001;
                end
            end
        end
    end
    // Only bytes received in this page write are programmed
    assign arr_we = copy_vld && valid[copy_idx]; // [R09]
    see_mem #(.DEPTH(PAGE_BYTES), .AW(PAGE_W), .DW(BYTE_W)) u_page_buf (
        .i_clk(i_mclk),
        .i_we(buf_we),
        .i_waddr(buf_waddr),
        .i_wdata(buf_wdata),
        .i_raddr(prog_idx[PAGE_W-1:0]),
        .o_rdata(buf_rdata)
    );
    see_mem #(.DEPTH(ARRAY_BYTES), .AW(ADDR_W), .DW(BYTE_W)) u_array (
        .i_clk(i_mclk),
        .i_we(arr_we),
        .i_waddr({wr_page, copy_idx}),
        .i_wdata(buf_rdata),
        .i_raddr(addr),
        .o_rdata(arr_rdata)
    );
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_sel_miss;
        byte_done && role == RL_DEVSEL && busy;
    endsequence
    sequence s_data_byte;
        byte_done && role == RL_DATA;
    endsequence
    sda_on_fall_a: assert property ($changed(o_sda_oe_n) |-> // [R01]
        $past(scl_fall) || $past(start_ev) || $past(stop_ev))
        else $error("data line changed outside clock low");
    drive_low_a: assert property (!o_sda_oe_n |-> !o_sda_out && st inside {ST_ACK, ST_TX}) // [R02]
        else $error("data line driven outside a reply");
    ack_ninth_a: assert property (byte_done && role != RL_DEVSEL |=> // [R14]
        !o_sda_oe_n && st == ST_ACK) else $error("received byte not acknowledged");
    busy_nack_a: assert property (s_sel_miss |=> st == ST_IDLE && o_sda_oe_n) // [R16]
        else $error("selection acknowledged while programming");
    protect_a: assert property (stop_ev && prot_s2 && !busy |=> !busy) // [R05]
        else $error("programming started while protected");
    timer_end_a: assert property ($fell(busy) |-> // [R10]
        $past(timer) == TIMER_W'(P_WRITE_CYCLES - 1))
        else $error("programming cycle wrong length");
    page_wrap_a: assert property (s_data_byte |=> addr[14:6] == $past(addr[14:6])) // [R17]
        else $error("write pointer left its page");
    start_seen_a: assert property (start_ev |=> st == ST_RX && cnt == 4'h0) // [R12]
        else $error("start not taken");
    stop_seen_a: assert property (stop_ev |=> st == ST_IDLE && o_sda_oe_n) // [R13]
        else $error("stop not taken");
    strap_match_a: assert property (byte_done && role == RL_DEVSEL && sh[3:1] != strap_s2 // [R03]
        |=> st == ST_IDLE) else $error("foreign selection acknowledged");
endmodule
`default_nettype wire

// ===== see_pkg.sv
`default_nettype none
package see_pkg;
    // Array geometry
    localparam int ARRAY_BYTES = 32768;
    localparam int ADDR_W = 15;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_W = 6;
    localparam int PAGE_COUNT = 512;
    localparam int PAGE_SEL_W = ADDR_W - PAGE_W;
    localparam int STRAP_W = 3;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] PAGE_END = 7'h40;
    // Bus type code sent ahead of the strap bits in the selection byte
    localparam logic [3:0] TYPE_CODE = 4'hA;
    // Self-timed programming cycle
    localparam int MCLK_MHZ = 100;
    localparam int WRITE_TIME_MS = 5;
    localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000 * MCLK_MHZ;
    localparam int TIMER_W = 19;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_ACK = 3'h2,
        ST_TX = 3'h3,
        ST_TXACK = 3'h4
    } see_state_t;

    typedef enum logic [1:0] {
        RL_DEVSEL = 2'h0,
        RL_ADDR_HI = 2'h1,
        RL_ADDR_LO = 2'h2,
        RL_DATA = 2'h3
    } see_role_t;
endpackage
`default_nettype wire

// ===== see_mem.sv
`timescale 1ns/1ps
`default_nettype none
module see_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int DW = 8
) (
    // Clock
    input wire logic i_clk,
    // Write port
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // Read port, data registered
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

// ===== see_host.sv
`timescale 1ns/1ps
`default_nettype none
module see_host (
    // Resolved bus wire
    input wire logic i_sda,
    // Controller side of the bus
    output logic o_scl,
    output logic o_sda_rel
);
    // Quarter of a 125 ns serial clock period
    localparam realtime Q = 31.25;
    initial begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end
    // Works from idle and as a repeated start from clock low
    task automatic start();
        o_sda_rel = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda_rel = 1'b0;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    // Clock stands high after the stop, as an idle bus does
    task automatic stop();
        o_sda_rel = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda_rel = 1'b1;
        #(4 * Q);
    endtask
    // Data set in clock low, sampled mid-high
    task automatic xfer(input logic b, output logic s);
        o_sda_rel = b;
        #Q o_scl = 1'b1;
        #Q s = i_sda;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic s);
        for (int i = 7; i >= 0; i--) xfer(d[i], s);
        xfer(1'b1, s);
    endtask
    // Released line lets the device answer; last byte is not acknowledged
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(last, s);
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import see_pkg::*;
    localparam int P_WR = 200;
    logic mclk, arst_n, scl, sda, sda_rel, sda_out, sda_oe_n, protect, busy;
    logic [2:0] straps;
    logic [31:0] seed = 32'h1A;
    logic [7:0] mem [int];
    int error_cnt = 0;
    int n_tests = 0;
    int busy_run = 0;
    // Pull-up wire: low when either side pulls
    assign sda = sda_rel & sda_oe_n;
    see_top #(.P_WRITE_CYCLES(P_WR)) i_see_top (.i_mclk(mclk), .i_arst_n(arst_n),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .i_bus_select_straps(straps), .i_protect(protect), .o_busy(busy));
    see_host i_see_host (.i_sda(sda), .o_scl(scl), .o_sda_rel(sda_rel));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Sampled on the falling edge, away from the edge that updates the flag
    always @(negedge mclk) busy_run = busy ? busy_run + 1 : busy_run;
    always @(sda_oe_n) if (arst_n === 1'b1) `CHK("oe in clk low", 1'b0, scl)
    always @(negedge sda_oe_n) if (arst_n === 1'b1) `CHK("drive level", 1'b0, sda_out)
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Write pointer wraps inside the page where the write began
    function automatic int page_slot(input logic [14:0] a, input int i);
        return int'({a[14:6], 6'(a[5:0] + i)});
    endfunction
    task automatic hdr(input logic [14:0] a);
        logic s;
        i_see_host.start();
        i_see_host.put_byte({TYPE_CODE, straps, 1'b0}, s);
        `CHK("sel ack", 1'b0, s)
        i_see_host.put_byte({1'(rnd()), a[14:8]}, s);
        `CHK("addr hi ack", 1'b0, s)
        i_see_host.put_byte(a[7:0], s);
        `CHK("addr lo ack", 1'b0, s)
    endtask
    task automatic wr_page(input logic [14:0] a, input int n);
        logic s;
        logic [7:0] d;
        hdr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'(rnd());
            i_see_host.put_byte(d, s);
            `CHK("data ack", 1'b0, s)
            if (!protect) mem[page_slot(a, i)] = d;
        end
        busy_run = 0;
        i_see_host.stop();
    endtask
    task automatic wait_prog(input logic exp_busy);
        logic s;
        repeat (8) @(negedge mclk);
        `CHK("busy", exp_busy, busy)
        if (exp_busy) begin
            i_see_host.start();
            i_see_host.put_byte({TYPE_CODE, straps, 1'b0}, s);
            `CHK("poll nack", 1'b1, s)
            i_see_host.stop();
            for (int k = 0; k < 2 * P_WR && busy; k++) @(negedge mclk);
            `CHK("prog time", 1'b1, busy_run >= P_WR && busy_run <= P_WR + 2)
        end
    endtask
    task automatic rd_check(input logic [14:0] a, input int n);
        logic s;
        logic [7:0] d;
        hdr(a);
        i_see_host.start();
        i_see_host.put_byte({TYPE_CODE, straps, 1'b1}, s);
        `CHK("rd sel ack", 1'b0, s)
        for (int i = 0; i < n; i++) begin
            i_see_host.get_byte(i == n - 1, d);
            `CHK("rd data", mem[15'(a + i)], d)
        end
        i_see_host.stop();
    endtask
    task automatic bad_sel(input logic [7:0] sel);
        logic s;
        i_see_host.start();
        i_see_host.put_byte(sel, s);
        `CHK("bad sel nack", 1'b1, s)
        i_see_host.stop();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #800us;
        error_cnt++;
        $display("BAD watchdog exp 0 got 1");
        wrap_up();
    end
    initial begin
        logic [14:0] a;
        int n;
        arst_n = 1'b0;
        straps = 3'h0;
        protect = 1'b0;
        repeat (10) @(posedge mclk);
        @(negedge mclk) arst_n = 1'b1;
        repeat (8) @(posedge mclk);
        // Round 0 keeps straps at zero, as when left open
        for (int r = 0; r < 4; r++) begin
            @(negedge mclk) straps = (r == 0) ? 3'h0 : 3'(rnd());
            n = (r == 0) ? 1 : (r == 1) ? 64 : (r == 2) ? 70 : 2 + int'(rnd() % 60);
            // Later rounds stay in one page so partial updates show
            a = (r < 2) ? 15'(rnd()) : {a[14:6], 6'(rnd())};
            wr_page(a, n);
            wait_prog(1'b1);
            if (r == 0) rd_check(a, 1);
            else rd_check({a[14:6], 6'h00}, 64);
            $display("test write round %0d done", r);
        end
        for (int st = 0; st < 8; st++) if (3'(st) != straps) bad_sel({TYPE_CODE, 3'(st), 1'b0});
        bad_sel({4'h5, straps, 1'b0});
        $display("test selection done");
        @(negedge mclk) protect = 1'b1;
        wr_page({a[14:6], 6'h00}, 5);
        wait_prog(1'b0);
        @(negedge mclk) protect = 1'b0;
        rd_check({a[14:6], 6'h00}, 64);
        $display("test protect done");
        wrap_up();
    end
endmodule
`default_nettype wire
